// >>> hdl/link_restart_params.svh
`ifndef LINK_RESTART_PARAMS_SVH
`define LINK_RESTART_PARAMS_SVH
// training sequences in a row that force a restart
`define TS_RUN_NEEDED      4'h8
// packet buffers with and without retry-on-error
`define PKT_BUF_RETRY      4'h8
`define PKT_BUF_PLAIN      4'h2
// lane count from which speed build is the default
`define SPEED_LANE_MIN     4
// transceiver reset hold, ns, and cycles at 10 ns
`define XCVR_RST_NS        200
`define CLK_PERIOD_NS      10
`define XCVR_RST_CYC       ((`XCVR_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// training handshake length in received training sequences
`define TRAIN_RUN_NEEDED   8'h10
// fifo defaults
`define FIFO_DEPTH         16
`define FIFO_WIDTH         16
`define HOLD_ON_LEVEL      5'h0C
`define HOLD_OFF_LEVEL     5'h04
`endif

// >>> hdl/link_restart_pkg.sv
package link_restart_pkg;
   typedef enum logic [2:0] {ST_XCVR_RST, ST_WAIT_LOCK, ST_INIT, ST_TRAIN, ST_UP} link_state_t;
   // per-cycle symbol from the lane decoder
   typedef struct packed {
      logic        valid;
      logic        is_training;
      logic        is_hold;
      logic [15:0] data;
   } rx_symbol_t;
   // status carrier to the user side
   typedef struct packed {
      logic link_up;
      logic link_error;
      logic hold_to_peer;
   } link_status_t;
endpackage

// >>> hdl/restart_fifo.sv
`timescale 1ns/1ps
`include "link_restart_params.svh"
// receive buffer between the lane decoder and the user port
module restart_fifo #(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // fill side
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   // drain side
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   // fill level
   output logic [$clog2(DEPTH):0]          level
);
   localparam int AW = $clog2(DEPTH);
   // refused at elaboration: the wrap-bit pointers need a power of two
   if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("restart_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_r;
   logic [AW:0]      rd_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // full when pointers differ only in the wrap bit
   assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data  = mem_r[rd_r[AW-1:0]];
   assign level     = wr_r - rd_r;

   // pointers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         if (push)
            wr_r <= wr_r + 1'b1;
         if (pop)
            rd_r <= rd_r + 1'b1;
      end
   end

   // storage, not reset: contents are qualified by the pointers
   always_ff @(posedge clock)
   begin
      if (push)
         mem_r[wr_r[AW-1:0]] <= in_data;
   end
endmodule

// >>> hdl/serial_link_restart_control.sv
// Overview of operation
// RQ1 - reset transceiver first, then initialize, then train before traffic
// RQ2 - while up, restart on its own only for a link error
// RQ3 - main reset takes link down; restart begins after release
// RQ4 - while down, send training sequences so the peer goes down
// RQ5 - restart after eight consecutive training sequences; other symbol clears count
// RQ6 - data just before a restart may be meaningless; user discards it
// RQ7 - eight packet buffers with retry-on-error, two without
// RQ8 - with flow control, send hold on fill level and obey peer hold
// RQ9 - speed build default for four or more lanes, else size
// RQ10 - with signal detect on, loss of signal is a link error
// RQ11 - main reset is driven synchronously to the core clock
// RQ12 - link-up output low in reset, init and training; high after
// RQ13 - one-cycle link-error pulse on every error-triggered restart; code pulses only for restarts from up, peer's too
`timescale 1ns/1ps
`include "link_restart_params.svh"
module serial_link_restart_control #(
   parameter int LANES          = 4,
   parameter bit RETRY_ON_ERROR = 1'b0,
   parameter bit FLOW_CONTROL   = 1'b1,
   parameter bit SIGNAL_DETECT  = 1'b0,
   parameter bit OPT_SPEED      = (LANES >= `SPEED_LANE_MIN), // RQ9
   parameter int FIFO_DEPTH     = `FIFO_DEPTH,
   parameter int XCVR_RST_CYC   = `XCVR_RST_CYC
) (
   // clock and reset
   input  wire logic                              clock,
   input  wire logic                              rst_n,
   // transceiver side
   output logic                                   xcvr_reset,
   input  wire logic                              xcvr_locked,
   input  wire logic [LANES-1:0]                  signal_lost,
   input  wire link_restart_pkg::rx_symbol_t      rx_sym,
   input  wire logic                              rx_error,
   output logic                                   tx_send_training,
   output logic                                   tx_send_hold,
   // user data port
   output logic                                   user_valid,
   input  wire logic                              user_ready,
   output logic [15:0]                            user_data,
   input  wire logic                              user_tx_valid,
   output logic                                   user_tx_ready,
   // status
   output link_restart_pkg::link_status_t         status,
   output logic [3:0]                             pkt_buffers,
   output logic                                   opt_speed
);
   // refused at elaboration; the reset counter is sixteen bits wide
   if (LANES < 1 || XCVR_RST_CYC < 1 || XCVR_RST_CYC > 17'h10000)
   begin : g_bad_param
      $error("serial_link_restart_control: bad lane count or reset length");
   end

   ////////////////////////////////////////////////////////////////////////////
   // loss of signal comes from the analog side: three-stage synchroniser
   logic [LANES-1:0] los_s1_r;
   logic [LANES-1:0] los_s2_r;
   logic [LANES-1:0] los_s3_r;
   logic             los_r;

   always_ff @(posedge clock)
   begin
      los_s1_r <= signal_lost;
      los_s2_r <= los_s1_r;
      los_s3_r <= los_s2_r;
   end

   // a change counts once stages two and three agree
   wire los_agree  = (los_s2_r == los_s3_r);
   wire los_nxt    = los_agree ? (|los_s3_r) : los_r;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         los_r <= 1'b0;
      else
         los_r <= los_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and counters
   link_restart_pkg::link_state_t state_r;
   link_restart_pkg::link_state_t state_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [3:0]  ts_run_r;
   logic [3:0]  ts_run_nxt;
   logic        up_r;
   logic        err_pulse_r;
   logic        train_tx_r;
   logic        xrst_r;

   // a link error: decoder error, or lost signal when detection is on
   wire link_err   = rx_error || (SIGNAL_DETECT && los_r); // RQ10
   wire ts_seen    = rx_sym.valid && rx_sym.is_training;
   wire non_ts     = rx_sym.valid && !rx_sym.is_training;
   // peer forced us down after eight training sequences in a row
   wire peer_down  = ts_seen && (ts_run_r == `TS_RUN_NEEDED - 4'h1); // RQ5
   wire up_state   = (state_r == link_restart_pkg::ST_UP);
   // only these two causes restart an operating link
   wire restart    = up_state && (link_err || peer_down); // RQ2
   wire cnt_done   = (cnt_r == 16'((XCVR_RST_CYC > 0) ? XCVR_RST_CYC - 1 : 0));
   wire train_done = (cnt_r == 16'(`TRAIN_RUN_NEEDED) - 16'h0001);

   // consecutive training run, cleared by any other symbol
   always_comb
   begin
      ts_run_nxt = ts_run_r;
      if (non_ts || !up_state)
         ts_run_nxt = 4'h0; // RQ5
      else if (ts_seen && ts_run_r != `TS_RUN_NEEDED)
         ts_run_nxt = ts_run_r + 4'h1; // RQ5
   end

   // bring-up sequence: transceiver reset, lock, init, train, up
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         link_restart_pkg::ST_XCVR_RST:
         begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_done)
            begin
               state_nxt = link_restart_pkg::ST_WAIT_LOCK; // RQ1
               cnt_nxt   = 16'h0000;
            end
         end
         link_restart_pkg::ST_WAIT_LOCK:
            if (xcvr_locked)
               state_nxt = link_restart_pkg::ST_INIT; // RQ1
         link_restart_pkg::ST_INIT:
            if (!link_err)
               state_nxt = link_restart_pkg::ST_TRAIN; // RQ1
         link_restart_pkg::ST_TRAIN:
         begin
            if (link_err || !xcvr_locked)
            begin
               state_nxt = link_restart_pkg::ST_XCVR_RST;
               cnt_nxt   = 16'h0000;
            end
            else if (ts_seen)
            begin
               cnt_nxt = cnt_r + 16'h0001;
               if (train_done)
               begin
                  state_nxt = link_restart_pkg::ST_UP;
                  cnt_nxt   = 16'h0000;
               end
            end
         end
         link_restart_pkg::ST_UP:
            if (restart)
            begin
               state_nxt = link_restart_pkg::ST_XCVR_RST; // RQ2
               cnt_nxt   = 16'h0000;
            end
      endcase
   end

   // main reset forces the link down; sequence starts on release
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_r     <= link_restart_pkg::ST_XCVR_RST; // RQ3
         cnt_r       <= 16'h0000;
         ts_run_r    <= 4'h0;
         up_r        <= 1'b0;
         err_pulse_r <= 1'b0;
         train_tx_r  <= 1'b1;
         xrst_r      <= 1'b1;
      end
      else
      begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         ts_run_r    <= ts_run_nxt;
         up_r        <= (state_nxt == link_restart_pkg::ST_UP); // RQ12
         err_pulse_r <= restart; // RQ13
         train_tx_r  <= (state_nxt != link_restart_pkg::ST_UP); // RQ4
         xrst_r      <= (state_nxt == link_restart_pkg::ST_XCVR_RST); // RQ1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer; data arriving just before a restart is passed on as is,
   // the user side must drop it
   logic       fifo_in_ready;
   logic [$clog2(FIFO_DEPTH):0] fifo_level_w;
   logic       fifo_out_valid;
   logic [15:0] fifo_out_data;
   logic       take_out;
   logic       uv_r;
   logic [15:0] ud_r;
   wire        data_in = rx_sym.valid && !rx_sym.is_training && !rx_sym.is_hold && up_state; // RQ6

   restart_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (data_in),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_sym.data),
      .out_valid (fifo_out_valid),
      .out_ready (take_out),
      .out_data  (fifo_out_data),
      .level     (fifo_level_w)
   );

   // registered output stage, refilled when empty or consumed
   assign take_out = !uv_r || user_ready;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         uv_r <= 1'b0;
         ud_r <= 16'h0000;
      end
      else if (take_out)
      begin
         uv_r <= fifo_out_valid;
         ud_r <= fifo_out_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flow control: hysteresis on fill, and obey peer hold
   logic hold_out_r;
   logic peer_hold_r;
   logic tx_rdy_r;
   wire  hold_on  = FLOW_CONTROL && (fifo_level_w >= `HOLD_ON_LEVEL || !fifo_in_ready);
   wire  hold_off = fifo_level_w <= `HOLD_OFF_LEVEL;
   wire  hold_nxt = hold_on ? 1'b1 : (hold_off ? 1'b0 : hold_out_r);
   wire  peer_nxt = !FLOW_CONTROL ? 1'b0 :
                    (rx_sym.valid && rx_sym.is_hold) ? 1'b1 :
                    rx_sym.valid ? 1'b0 : peer_hold_r;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         hold_out_r  <= 1'b0;
         peer_hold_r <= 1'b0;
         tx_rdy_r    <= 1'b0;
      end
      else
      begin
         hold_out_r  <= hold_nxt; // RQ8
         peer_hold_r <= peer_nxt; // RQ8
         tx_rdy_r    <= (state_nxt == link_restart_pkg::ST_UP) && !peer_nxt; // RQ8
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   logic [3:0] bufs_r;
   logic       speed_r;

   always_ff @(posedge clock)
   begin
      bufs_r  <= RETRY_ON_ERROR ? `PKT_BUF_RETRY : `PKT_BUF_PLAIN; // RQ7
      speed_r <= OPT_SPEED; // RQ9
   end

   assign xcvr_reset          = xrst_r;
   assign tx_send_training    = train_tx_r;
   assign tx_send_hold        = hold_out_r;
   assign user_valid          = uv_r;
   assign user_data           = ud_r;
   assign user_tx_ready       = tx_rdy_r;
   assign status.link_up      = up_r;
   assign status.link_error   = err_pulse_r;
   assign status.hold_to_peer = hold_out_r;
   assign pkt_buffers         = bufs_r;
   assign opt_speed           = speed_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_train_first;
      @(posedge clock) disable iff (!rst_n)
      $rose(up_r) |-> $past(state_r, 2) == link_restart_pkg::ST_TRAIN;
   endproperty
   a_train_first: assert property (p_train_first) else $error("link up without training"); // RQ1

   property p_only_err_restart;
      @(posedge clock) disable iff (!rst_n)
      up_state && !link_err && !peer_down |=> state_r == link_restart_pkg::ST_UP;
   endproperty
   a_only_err_restart: assert property (p_only_err_restart) else $error("spurious restart"); // RQ2

   property p_reset_down;
      @(posedge clock)
      !rst_n |=> !up_r && xrst_r && train_tx_r;
   endproperty
   a_reset_down: assert property (p_reset_down) else $error("reset did not take link down"); // RQ3

   property p_ts_when_down;
      @(posedge clock) disable iff (!rst_n)
      !up_r |-> train_tx_r && !tx_rdy_r;
   endproperty
   a_ts_when_down: assert property (p_ts_when_down) else $error("no training while down"); // RQ4

   property p_eight_ts;
      @(posedge clock) disable iff (!rst_n)
      up_state && !link_err && !non_ts && ts_seen && ts_run_r == 4'h7 |=> !up_state;
   endproperty
   a_eight_ts: assert property (p_eight_ts) else $error("eighth training symbol ignored"); // RQ5

   property p_err_pulse;
      @(posedge clock) disable iff (!rst_n)
      err_pulse_r |-> $past(up_state) && !up_state ##1 !err_pulse_r;
   endproperty
   a_err_pulse: assert property (p_err_pulse) else $error("bad error pulse"); // RQ13

   property p_bufs;
      @(posedge clock) disable iff (!rst_n)
      ##1 pkt_buffers == (RETRY_ON_ERROR ? 4'h8 : 4'h2);
   endproperty
   a_bufs: assert property (p_bufs) else $error("wrong buffer count"); // RQ7

   property p_peer_hold;
      @(posedge clock) disable iff (!rst_n)
      FLOW_CONTROL && rx_sym.valid && rx_sym.is_hold |=> !user_tx_ready;
   endproperty
   a_peer_hold: assert property (p_peer_hold) else $error("peer hold ignored"); // RQ8

   property p_los_err;
      @(posedge clock) disable iff (!rst_n)
      SIGNAL_DETECT && los_r && up_state |=> !up_state;
   endproperty
   a_los_err: assert property (p_los_err) else $error("loss of signal ignored"); // RQ10
endmodule

// >>> test/peer_link_model.sv
`timescale 1ns/1ps
// far-end link core: lock report and symbol stream
module peer_link_model #(
   parameter int LOCK_DLY = 3
) (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // near-end transceiver control
   input  wire logic                    xcvr_reset,
   // toward the near end
   output link_restart_pkg::rx_symbol_t rx_sym,
   output logic                         xcvr_locked
);
   logic [7:0]                   lock_cnt;
   logic [15:0]                  noise = 16'hA5C3;
   logic                         drive_en = 1'b0;
   link_restart_pkg::rx_symbol_t sym_r;
   ////////////////////////////////////////////////////////////////
   // lock after reset lets go; idle fields churn so stale values never pass
   always @(posedge clock)
   begin
      noise <= {noise[14:0], noise[15] ^ noise[13]};
      if (xcvr_reset || !rst_n)
         lock_cnt <= 8'h00;
      else if (lock_cnt != 8'hFF)
         lock_cnt <= lock_cnt + 8'h01;
   end
   assign xcvr_locked = (lock_cnt >= LOCK_DLY);
   assign rx_sym = drive_en ? sym_r : {1'b0, noise[0], noise[1], noise};
   ////////////////////////////////////////////////////////////////
   // n symbols back to back after one idle cycle, called at a falling edge;
   // the idle cycle keeps two runs in a row from flipping drive_en in one step
   task automatic send_run(input logic [1:0] kind, input int n, input logic [15:0] d0);
      @(negedge clock);
      for (int i = 0; i < n; i++)
      begin
         sym_r = {1'b1, kind == 2'h1, kind == 2'h2, d0 + 16'(i)};
         drive_en = 1'b1;
         @(negedge clock);
      end
      drive_en = 1'b0;
   endtask
endmodule

// >>> test/serial_link_restart_control_tb.sv
`timescale 1ns/1ps
module serial_link_restart_control_tb;
   localparam int RST_CYC = 2;
   logic                           clock = 1'b0;
   logic                           rst_n = 1'b0;
   logic                           xcvr_reset, xcvr_locked, tx_send_training, tx_send_hold;
   logic                           rx_error = 1'b0;
   logic [3:0]                     signal_lost = 4'h0;
   logic                           user_ready = 1'b1;
   logic                           user_tx_valid = 1'b1;
   logic                           user_valid, user_tx_ready, opt_speed;
   logic [15:0]                    user_data;
   logic [3:0]                     pkt_buffers;
   link_restart_pkg::rx_symbol_t   rx_sym;
   link_restart_pkg::link_status_t status;
   logic [15:0]                    got[$];
   int                             bad_count = 0;
   int                             checks_done = 0;
   ////////////////////////////////////////////////////////////////
   always #5 clock = ~clock;
   serial_link_restart_control #(.LANES(4), .RETRY_ON_ERROR(1'b0), .FLOW_CONTROL(1'b1),
      .SIGNAL_DETECT(1'b1), .XCVR_RST_CYC(RST_CYC)) u_dut (
      .clock(clock), .rst_n(rst_n), .xcvr_reset(xcvr_reset), .xcvr_locked(xcvr_locked),
      .signal_lost(signal_lost), .rx_sym(rx_sym), .rx_error(rx_error),
      .tx_send_training(tx_send_training), .tx_send_hold(tx_send_hold), .user_valid(user_valid),
      .user_ready(user_ready), .user_data(user_data), .user_tx_valid(user_tx_valid),
      .user_tx_ready(user_tx_ready), .status(status), .pkt_buffers(pkt_buffers), .opt_speed(opt_speed));
   peer_link_model u_peer (.clock(clock), .rst_n(rst_n), .xcvr_reset(xcvr_reset),
      .rx_sym(rx_sym), .xcvr_locked(xcvr_locked));
   // words accepted at the user port
   always @(posedge clock)
      if (rst_n && user_valid === 1'b1 && user_ready === 1'b1)
         got.push_back(user_data);
   ////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // reset hold, lock, then training up to link-up
   task automatic bring_up();
      int n;
      n = 0;
      while (xcvr_reset !== 1'b0 && n < 100)
      begin
         check("up_in_xrst", status.link_up, 0);
         @(negedge clock);
         n++;
      end
      check("xrst_len", n >= RST_CYC - 1 && n <= RST_CYC + 2, 1);
      while (xcvr_locked !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      repeat (3) @(negedge clock);
      u_peer.send_run(2'h1, 15, 16'h0000);
      check("up_early", status.link_up, 0);
      check("train_tx", tx_send_training, 1);
      u_peer.send_run(2'h1, 1, 16'h0000);
      repeat (2) @(negedge clock);
      check("up_done", status.link_up, 1);
      check("train_off", tx_send_training, 0);
      check("tx_ready", user_tx_ready, 1);
   endtask
   // link drops; error pulse checked against pulse, which is set for every restart, the peer's included
   task automatic expect_restart(input logic pulse);
      int n;
      n = 0;
      while (status.link_up !== 1'b0 && n < 8)
      begin
         @(negedge clock);
         n++;
      end
      check("down", status.link_up, 0);
      check("err_pulse", status.link_error, pulse);
      check("xrst_again", xcvr_reset, 1);
      check("force_peer", tx_send_training, 1);
      @(negedge clock);
      check("err_once", status.link_error, 0);
   endtask
   ////////////////////////////////////////////////////////////////
   // watchdog: whole run is a few hundred cycles
   initial
   begin
      #200000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      repeat (10) @(negedge clock);
      check("rst_xrst", xcvr_reset, 1);
      check("rst_train", tx_send_training, 1);
      check("rst_up", status.link_up, 0);
      check("rst_hold", tx_send_hold, 0);
      check("bufs", pkt_buffers, 4'h2);
      check("speed", opt_speed, 1);
      rst_n = 1'b1;
      bring_up();
      // plain data and peer hold
      u_peer.send_run(2'h0, 4, 16'h1000);
      repeat (6) @(negedge clock);
      check("data_n", got.size(), 4);
      foreach (got[i]) check("data", got[i], 16'h1000 + 16'(i));
      u_peer.send_run(2'h2, 1, 16'h0000);
      @(negedge clock);
      check("peer_hold", user_tx_ready, 0);
      u_peer.send_run(2'h0, 1, 16'h2000);
      @(negedge clock);
      check("peer_go", user_tx_ready, 1);
      check("no_restart", status.link_up, 1);
      // let the last word leave the output stage before the drain stalls
      @(negedge clock);
      check("go_data", got[4], 16'h2000);
      // fill past full with the drain stalled, then empty it
      got.delete();
      user_ready = 1'b0;
      u_peer.send_run(2'h0, 10, 16'h3000);
      check("hold_low", tx_send_hold, 0);
      u_peer.send_run(2'h0, 10, 16'h300A);
      check("hold_high", tx_send_hold, 1);
      check("hold_stat", status.hold_to_peer, 1);
      user_ready = 1'b1;
      repeat (40) @(negedge clock);
      check("hold_rel", tx_send_hold, 0);
      check("fill_n", got.size(), 17);
      for (int i = 0; i < 17; i++)
         check("fill", got[i], 16'h3000 + 16'(i));
      // training runs broken by data must not restart; idle gaps do not break a run
      u_peer.send_run(2'h1, 7, 16'h0000);
      u_peer.send_run(2'h0, 1, 16'h4000);
      u_peer.send_run(2'h1, 7, 16'h0000);
      repeat (3) @(negedge clock);
      check("run7", status.link_up, 1);
      u_peer.send_run(2'h0, 1, 16'h4001);
      u_peer.send_run(2'h1, 4, 16'h0000);
      repeat (2) @(negedge clock);
      u_peer.send_run(2'h1, 4, 16'h0000);
      expect_restart(1'b1);
      got.delete();
      bring_up();
      // decoder error
      rx_error = 1'b1;
      @(negedge clock);
      rx_error = 1'b0;
      expect_restart(1'b1);
      bring_up();
      // lost signal on one lane
      signal_lost = 4'h4;
      expect_restart(1'b1);
      signal_lost = 4'h0;
      bring_up();
      // main reset in mid-run
      rst_n = 1'b0;
      repeat (4) @(negedge clock);
      check("mr_up", status.link_up, 0);
      check("mr_train", tx_send_training, 1);
      check("mr_noerr", status.link_error, 0);
      rst_n = 1'b1;
      bring_up();
      complete_run();
   end
endmodule
